// [i2cm_defs.svh]
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 6-bit byte addresses on the register bus, one aligned word per register
// Notes:   Definitions only
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH
////////////////////////////////////////////////////////////////////////////////
`define I2CM_CTRL_OFS      6'h00
`define I2CM_TARGET_OFS    6'h04
`define I2CM_DATA_CMD_OFS  6'h08
`define I2CM_STATUS_OFS    6'h0C
`define I2CM_INT_STAT_OFS  6'h10
`define I2CM_INT_MASK_OFS  6'h14
`define I2CM_SS_HCNT_OFS   6'h18
`define I2CM_SS_LCNT_OFS   6'h1C
`define I2CM_FS_HCNT_OFS   6'h20
`define I2CM_FS_LCNT_OFS   6'h24
`define I2CM_FS_SPKLEN_OFS 6'h28
`define I2CM_HS_SPKLEN_OFS 6'h2C
////////////////////////////////////////////////////////////////////////////////
`define I2CM_CTRL_EN       0
`define I2CM_CTRL_FAST     1
`define I2CM_CTRL_HS       2
`define I2CM_CTRL_ADDR10   3
`define I2CM_CTRL_MASTER   4
`define I2CM_CMD_RD        8
`define I2CM_CMD_STOP      9
`define I2CM_INT_TX        0
`define I2CM_INT_RX        1
`define I2CM_INT_NACK      2
`define I2CM_INT_ARB       3
////////////////////////////////////////////////////////////////////////////////
`define I2CM_SS_HCNT_RST   16'h0007
`define I2CM_SS_LCNT_RST   16'h000C
`define I2CM_FS_HCNT_RST   16'h0007
`define I2CM_FS_LCNT_RST   16'h000F
`define I2CM_SPKLEN_RST    8'h01
`define I2CM_HIGH_EXTRA    16'h0006
`define I2CM_RESP_OKAY     2'h0
`define I2CM_RESP_SLVERR   2'h2
`endif

// [i2cm_pkg.sv]
// Purpose: Types shared by the two-wire master controller
// Assumes: Constants live in i2cm_defs.svh
// Notes:   State of each module is one packed struct
package i2cm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RS_LOW, ST_RS_HIGH, ST_START, ST_LOW, ST_HIGH, ST_STOP_LOW, ST_STOP_HIGH
  } i2cm_eng_type;
  typedef struct packed {
    logic aw_have; logic [5:0] aw_addr; logic w_have; logic [31:0] w_data; logic [3:0] w_strb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic en; logic fast_speed; logic [6:0] tar;
    logic [15:0] ss_h; logic [15:0] ss_l; logic [15:0] fs_h; logic [15:0] fs_l;
    logic [7:0] fast_spike_filter_length; logic [7:0] highspeed_spike_filter_length;
    logic [3:0] stat; logic [3:0] mask; logic irq;
    logic [7:0] rx; logic cmd_rd; logic cmd_stop; logic [7:0] cmd_data;
    i2cm_eng_type st; logic [8:0] shift; logic [3:0] bitn; logic phase; logic stop_free;
    logic held; logic scl_pull; logic sda_pull;
  } i2cm_top_state_type;
  typedef struct packed {
    logic s1; logic s2; logic flt; logic [7:0] cnt;
  } i2cm_sync_state_type;
  typedef struct packed {
    logic [15:0] cnt;
  } i2cm_timer_state_type;
endpackage

// [i2cm_line_sync.sv]
// Purpose: Two-flop synchroniser and spike filter for one bus line sense input
// Assumes: Idle bus level is high
// Notes:   A change must persist spike_len+1 cycles before it is seen
module i2cm_line_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       line_in,
  input  wire logic [7:0] spike_len,
  output logic            line_out
);
  i2cm_pkg::i2cm_sync_state_type s;
  i2cm_pkg::i2cm_sync_state_type n;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    n.s1 = line_in;
    n.s2 = s.s1;
    if (s.s2 == s.flt) begin
      n.cnt = 8'h00;
    end else if (s.cnt >= spike_len) begin
      n.flt = s.s2;
      n.cnt = 8'h00;
    end else begin
      n.cnt = s.cnt + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{s1: 1'b1, s2: 1'b1, flt: 1'b1, cnt: 8'h00};
    end else if (ce) begin
      s <= n;
    end
  end
  assign line_out = s.flt;
  ////////////////////////////////////////////////////////////////////////////////
  filter_follows_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    $changed(s.flt) |-> (s.flt == $past(s.s2)))
    else $error("filtered line changed to a level not sampled");
endmodule

// [i2cm_phase_timer.sv]
// Purpose: Down counter timing the low and high phases of the serial clock
// Assumes: load and hold come from the engine on the same clock
// Notes:   hold freezes the count while a slave stretches the clock
module i2cm_phase_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] len,
  input  wire logic        hold,
  output logic             zero
);
  i2cm_pkg::i2cm_timer_state_type s;
  i2cm_pkg::i2cm_timer_state_type n;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    if (load) begin
      n.cnt = len;
    end else if (!hold && (s.cnt != 16'h0000)) begin
      n.cnt = s.cnt - 16'h0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{cnt: 16'h0000};
    end else if (ce) begin
      s <= n;
    end
  end
  assign zero = (s.cnt == 16'h0000);
  ////////////////////////////////////////////////////////////////////////////////
  stretch_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (hold && !load) |=> (s.cnt == $past(s.cnt)))
    else $error("phase count moved while clock stretched");
endmodule

// [i2cm_top.sv]
// Purpose: Two-wire serial bus master with AXI4-Lite registers and one interrupt
// Assumes: One clock aclk for bus slave and core; pins are open drain with pull-ups
// Notes:   One byte per command: start, address, one data byte, optional stop
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`include "i2cm_defs.svh"
module i2cm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_line_sense,
  input  wire logic        sda_line_sense,
  output logic             scl_drive_level,
  output logic             scl_pull_low_drive,
  output logic             sda_drive_level,
  output logic             sda_pull_low_drive,
  output logic             irq
);
  i2cm_pkg::i2cm_top_state_type s;
  i2cm_pkg::i2cm_top_state_type n;
  logic [1:0]  sense;
  logic [1:0]  filt;
  logic        tmr_load;
  logic [15:0] tmr_len;
  logic        tmr_hold;
  logic        tmr_zero;
  logic [15:0] lo_len;
  logic [15:0] hi_len;
  logic        drv;
  logic [32:0] wr_old;
  logic [32:0] rd_val;
  logic [31:0] wv;
  logic [3:0]  clr;
  logic [3:0]  ev;
  logic        wr_go;
  ////////////////////////////////////////////////////////////////////////////////
  localparam i2cm_pkg::i2cm_top_state_type RST = '{
    ss_h: `I2CM_SS_HCNT_RST, ss_l: `I2CM_SS_LCNT_RST,
    fs_h: `I2CM_FS_HCNT_RST, fs_l: `I2CM_FS_LCNT_RST,
    fast_spike_filter_length: `I2CM_SPKLEN_RST,
    highspeed_spike_filter_length: `I2CM_SPKLEN_RST,
    st: i2cm_pkg::ST_IDLE, default: '0};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bit 32 flags a mapped address
  function automatic logic [32:0] word_at(input i2cm_pkg::i2cm_top_state_type st,
                                          input logic [5:0] a, input logic [1:0] ln);
    logic [32:0] r;
    r = 33'h000000000;
    case ({a[5:2], 2'b00})
      `I2CM_CTRL_OFS:      r = {1'b1, 27'h0, 1'b1, 1'b0, 1'b0, st.fast_speed, st.en};
      `I2CM_TARGET_OFS:    r = {1'b1, 25'h0, st.tar};
      `I2CM_DATA_CMD_OFS:  r = {1'b1, 24'h0, st.rx};
      `I2CM_STATUS_OFS:    r = {1'b1, 28'h0, ln, st.held, (st.st != i2cm_pkg::ST_IDLE)};
      `I2CM_INT_STAT_OFS:  r = {1'b1, 28'h0, st.stat};
      `I2CM_INT_MASK_OFS:  r = {1'b1, 28'h0, st.mask};
      `I2CM_SS_HCNT_OFS:   r = {1'b1, 16'h0, st.ss_h};
      `I2CM_SS_LCNT_OFS:   r = {1'b1, 16'h0, st.ss_l};
      `I2CM_FS_HCNT_OFS:   r = {1'b1, 16'h0, st.fs_h};
      `I2CM_FS_LCNT_OFS:   r = {1'b1, 16'h0, st.fs_l};
      `I2CM_FS_SPKLEN_OFS: r = {1'b1, 24'h0, st.fast_spike_filter_length};
      `I2CM_HS_SPKLEN_OFS: r = {1'b1, 24'h0, st.highspeed_spike_filter_length};
      default:             r = 33'h000000000;
    endcase
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Sense inputs come from pins, so each passes two flops and the spike filter
  assign sense = {sda_line_sense, scl_line_sense};
  for (genvar g = 0; g < 2; g++) begin : g_line
    i2cm_line_sync u_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .line_in   (sense[g]),
      .spike_len (s.fast_spike_filter_length),
      .line_out  (filt[g])
    );
  end

  i2cm_phase_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (tmr_load),
    .len     (tmr_len),
    .hold    (tmr_hold),
    .zero    (tmr_zero)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Low lasts count+1 cycles, high count+7 cycles plus any stretching
  assign lo_len   = s.fast_speed ? s.fs_l : s.ss_l;
  assign hi_len   = 16'((s.fast_speed ? s.fs_h : s.ss_h) + `I2CM_HIGH_EXTRA);
  assign tmr_hold = ((s.st == i2cm_pkg::ST_HIGH) || (s.st == i2cm_pkg::ST_RS_HIGH) ||
                     (s.st == i2cm_pkg::ST_STOP_HIGH)) && !filt[0];
  assign drv      = ((s.bitn == 4'h8) == (s.phase && s.cmd_rd));
  assign wr_old   = word_at(s, s.aw_addr, filt);
  assign rd_val   = word_at(s, s_axi_araddr, filt);

  always_comb begin
    n        = s;
    tmr_load = 1'b0;
    tmr_len  = lo_len;
    wv       = merge(wr_old[31:0], s.w_data, s.w_strb);
    clr      = 4'h0;
    ev       = 4'h0;
    wr_go    = 1'b0;
    // Register bus write: address and data may arrive in either order
    if (s_axi_awvalid && !s.aw_have && !s.bvalid) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_have && !s.bvalid) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_old[32] ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
      case ({s.aw_addr[5:2], 2'b00})
        // High-speed and 10-bit requests are dropped on write
        `I2CM_CTRL_OFS: begin
          n.en         = wv[`I2CM_CTRL_EN];
          n.fast_speed = wv[`I2CM_CTRL_FAST];
        end
        `I2CM_TARGET_OFS:    n.tar = wv[6:0];
        `I2CM_DATA_CMD_OFS: begin
          // A command while busy or disabled is dropped
          if ((s.st == i2cm_pkg::ST_IDLE) && s.en) begin
            wr_go      = 1'b1;
            n.cmd_data = wv[7:0];
            n.cmd_rd   = wv[`I2CM_CMD_RD];
            n.cmd_stop = wv[`I2CM_CMD_STOP];
          end
        end
        `I2CM_INT_STAT_OFS:  clr = s.w_strb[0] ? s.w_data[3:0] : 4'h0;
        `I2CM_INT_MASK_OFS:  n.mask = wv[3:0];
        `I2CM_SS_HCNT_OFS:   n.ss_h = wv[15:0];
        `I2CM_SS_LCNT_OFS:   n.ss_l = wv[15:0];
        `I2CM_FS_HCNT_OFS:   n.fs_h = wv[15:0];
        `I2CM_FS_LCNT_OFS:   n.fs_l = wv[15:0];
        `I2CM_FS_SPKLEN_OFS: n.fast_spike_filter_length = wv[7:0];
        `I2CM_HS_SPKLEN_OFS: n.highspeed_spike_filter_length = wv[7:0];
        default: ;
      endcase
    end
    // Register bus read
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_val[31:0];
      n.rresp  = rd_val[32] ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
    end
    // Bus engine; every line change is a pull or a release
    case (s.st)
      i2cm_pkg::ST_IDLE: begin
        if (wr_go) begin
          tmr_load = 1'b1;
          if (s.held) begin
            n.st       = i2cm_pkg::ST_RS_LOW;
            n.sda_pull = 1'b0;
          end else begin
            n.st       = i2cm_pkg::ST_START;
            n.sda_pull = 1'b1;
            tmr_len    = hi_len;
          end
        end
      end
      i2cm_pkg::ST_RS_LOW: begin
        if (tmr_zero) begin
          n.st       = i2cm_pkg::ST_RS_HIGH;
          n.scl_pull = 1'b0;
          tmr_load   = 1'b1;
          tmr_len    = hi_len;
        end
      end
      i2cm_pkg::ST_RS_HIGH: begin
        if (tmr_zero) begin
          n.st       = i2cm_pkg::ST_START;
          n.sda_pull = 1'b1;
          tmr_load   = 1'b1;
          tmr_len    = hi_len;
        end
      end
      i2cm_pkg::ST_START: begin
        if (tmr_zero) begin
          n.st       = i2cm_pkg::ST_LOW;
          n.scl_pull = 1'b1;
          n.shift    = {s.tar, s.cmd_rd, 1'b1};
          n.bitn     = 4'h0;
          n.phase    = 1'b0;
          tmr_load   = 1'b1;
        end
      end
      i2cm_pkg::ST_LOW: begin
        n.sda_pull = !s.shift[8];
        if (tmr_zero) begin
          n.st       = i2cm_pkg::ST_HIGH;
          n.scl_pull = 1'b0;
          tmr_load   = 1'b1;
          tmr_len    = hi_len;
        end
      end
      i2cm_pkg::ST_HIGH: begin
        if (filt[0] && drv && !s.sda_pull && !filt[1]) begin
          // Another master holds data low: give up the bus at once
          ev[`I2CM_INT_ARB] = 1'b1;
          n.st              = i2cm_pkg::ST_IDLE;
          n.held            = 1'b0;
        end else if (tmr_zero) begin
          n.shift    = {s.shift[7:0], filt[1]};
          n.scl_pull = 1'b1;
          tmr_load   = 1'b1;
          n.st       = i2cm_pkg::ST_LOW;
          if (s.bitn != 4'h8) begin
            n.bitn = s.bitn + 4'h1;
          end else if (!s.phase) begin
            if (filt[1]) begin
              ev[`I2CM_INT_NACK] = 1'b1;
              n.st               = i2cm_pkg::ST_STOP_LOW;
            end else begin
              n.phase = 1'b1;
              n.bitn  = 4'h0;
              n.shift = s.cmd_rd ? {8'hFF, s.cmd_stop} : {s.cmd_data, 1'b1};
            end
          end else begin
            if (s.cmd_rd) begin
              n.rx              = s.shift[7:0];
              ev[`I2CM_INT_RX]  = 1'b1;
            end else begin
              ev[`I2CM_INT_TX]   = 1'b1;
              ev[`I2CM_INT_NACK] = filt[1];
            end
            if (s.cmd_stop || (!s.cmd_rd && filt[1])) begin
              n.st = i2cm_pkg::ST_STOP_LOW;
            end else begin
              // Clock held low until the next command brings a repeated start
              n.st     = i2cm_pkg::ST_IDLE;
              n.held   = 1'b1;
              tmr_load = 1'b0;
            end
          end
        end
      end
      i2cm_pkg::ST_STOP_LOW: begin
        n.sda_pull = 1'b1;
        if (tmr_zero) begin
          n.st        = i2cm_pkg::ST_STOP_HIGH;
          n.scl_pull  = 1'b0;
          n.stop_free = 1'b0;
          tmr_load    = 1'b1;
          tmr_len     = hi_len;
        end
      end
      i2cm_pkg::ST_STOP_HIGH: begin
        if (tmr_zero && !s.stop_free) begin
          // Release data while clock is high, then keep the bus free one high time
          n.sda_pull  = 1'b0;
          n.stop_free = 1'b1;
          tmr_load    = 1'b1;
          tmr_len     = hi_len;
        end else if (tmr_zero) begin
          n.st   = i2cm_pkg::ST_IDLE;
          n.held = 1'b0;
        end
      end
      default: n.st = i2cm_pkg::ST_IDLE;
    endcase
    // A new event wins over a write-one clear in the same cycle
    n.stat = (s.stat & ~clr) | ev;
    n.irq  = |(n.stat & n.mask);
  end

  // Core and register interface share this one clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST;
    end else if (ce) begin
      s <= n;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready      = !s.aw_have && !s.bvalid;
  assign s_axi_wready       = !s.w_have && !s.bvalid;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = !s.rvalid;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign scl_drive_level    = 1'b0;
  assign sda_drive_level    = 1'b0;
  assign scl_pull_low_drive = s.scl_pull;
  assign sda_pull_low_drive = s.sda_pull;
  assign irq                = s.irq;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  ctrl_fixed_bits_a: assert property (
    (s_axi_arvalid && s_axi_arready && (s_axi_araddr == `I2CM_CTRL_OFS))
    |=> (s_axi_rdata[`I2CM_CTRL_MASTER] && !s_axi_rdata[`I2CM_CTRL_HS]))
    else $error("control read shows slave or high-speed mode");
  addr_frame_a: assert property (
    (s.st == i2cm_pkg::ST_START) && tmr_zero |=> (s.shift == {s.tar, s.cmd_rd, 1'b1}))
    else $error("address byte not seven bits plus direction");
  speed_low_len_a: assert property (
    (s.st == i2cm_pkg::ST_HIGH) && tmr_zero && !drv && (s.bitn != 4'h8) |->
    (tmr_len == (s.fast_speed ? s.fs_l : s.ss_l)))
    else $error("low phase length not from selected speed");
  irq_on_event_a: assert property (
    ev[`I2CM_INT_TX] && s.mask[`I2CM_INT_TX] |=> (s.stat[`I2CM_INT_TX] && irq))
    else $error("unmasked event did not raise interrupt");
  sticky_set_wins_a: assert property (
    (ev != 4'h0) |=> ((s.stat & $past(ev)) == $past(ev)))
    else $error("event lost against clear");
  idle_released_a: assert property (
    (s.st == i2cm_pkg::ST_IDLE) && !s.held |-> !scl_pull_low_drive && !sda_pull_low_drive)
    else $error("line pulled while bus idle");
  stretch_wait_a: assert property (
    (s.st == i2cm_pkg::ST_HIGH) && !filt[0] && !(drv && !s.sda_pull && !filt[1])
    |=> (s.st == i2cm_pkg::ST_HIGH) && !scl_pull_low_drive)
    else $error("high phase left while clock line low");
  start_order_a: assert property (
    (s.st == i2cm_pkg::ST_IDLE) && !s.held && wr_go
    |=> (s.st == i2cm_pkg::ST_START) && sda_pull_low_drive && !scl_pull_low_drive)
    else $error("start not data low with clock released");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

// [i2cm_slave_model.sv]
// Purpose: Behavioural target device on the two-wire bus
// Assumes: Both lines have pull-ups; the model only ever pulls sda low
// Notes:   Acks its own address and written bytes, returns rd_byte on reads
module i2cm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  output logic            sda_pull,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  int         n = 0;
  logic       adr = 0, sel = 0, rd = 0;
  logic [7:0] sh = 8'h00;
  initial sda_pull = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    n = 0;
    adr = 1;
  end
  always @(posedge sda) if (scl) begin
    adr = 0;
    sel = 0;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n++;
    if (n == 8 && adr) begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
    end
    if (n == 8 && !adr && sel && !rd) got = sh;
  end
  // Lines change only while scl is low, so a start or stop is never faked
  always @(negedge scl) begin
    sda_pull = 0;
    if (n == 9) begin
      n = 0;
      adr = 0;
    end
    if (n == 8 && sel && (adr || !rd)) sda_pull = 1;
    if (n < 8 && !adr && sel && rd) sda_pull = !rd_byte[7 - n];
  end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the two-wire master controller
// Assumes: One target model on the bus; wires resolved as wired-AND with pull-ups
// Notes:   Bus answers are sampled at the falling edge, stable until the next rise
`include "i2cm_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h2A;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid, irq;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rsp;
  logic        scl_pull, sda_pull, sda_slv, scl_lvl, sda_lvl, scl, sda;
  logic [7:0]  got, d, rd_byte = 8'h00;
  int          err_total = 0, comparisons = 0, lo = 0, lo_max = 0, i;
  logic [5:0]  ofs [7] = '{`I2CM_CTRL_OFS, `I2CM_SS_HCNT_OFS, `I2CM_SS_LCNT_OFS,
    `I2CM_FS_HCNT_OFS, `I2CM_FS_LCNT_OFS, `I2CM_FS_SPKLEN_OFS, `I2CM_HS_SPKLEN_OFS};
  logic [31:0] ev [7] = '{32'h10, 32'h7, 32'hC, 32'h7, 32'hF, 32'h1, 32'h1};
  assign scl = !scl_pull;
  assign sda = !(sda_pull || sda_slv);
  i2cm_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_line_sense(scl), .sda_line_sense(sda), .scl_drive_level(scl_lvl),
    .scl_pull_low_drive(scl_pull), .sda_drive_level(sda_lvl), .sda_pull_low_drive(sda_pull),
    .irq(irq));
  i2cm_slave_model #(.ADDR(SLV)) slv (.scl(scl), .sda(sda), .rd_byte(rd_byte),
    .sda_pull(sda_slv), .got(got));
  ////////////////////////////////////////////////////////////////////////////////
  // One clock feeds core and register bus, so core is never slower
  initial forever #50 aclk = ~aclk;
  // Longest low run of scl, in core cycles
  always @(negedge aclk) begin
    if (aresetn) `CHK({scl_lvl, sda_lvl}, 2'b00)
    lo <= scl ? 0 : lo + 1;
    if (scl && lo > lo_max) lo_max <= lo;
  end
  function automatic int low_cycles(input int cnt);
    return cnt + 1;
  endfunction
  task automatic axw(input logic [5:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready; hw = wvalid && wready; hb = bvalid; rsp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
    end while (!hb);
    // Let one edge pass so a following call never re-raises bready in this step
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [5:0] a);
    logic ha, hr;
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready; hr = rvalid; rdat = rdata; rsp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 0;
    end while (!hr);
    rready <= 0;
    @(posedge aclk);
  endtask
  // Polls busy, so completion never depends on the interrupt path
  task automatic xfer(input logic [31:0] cmd);
    lo_max = 0;
    axw(`I2CM_DATA_CMD_OFS, cmd);
    do axr(`I2CM_STATUS_OFS); while (rdat[0] !== 1'b0);
  endtask
  task automatic clr(input logic [3:0] e);
    axr(`I2CM_INT_STAT_OFS);
    `CHK(rdat[3:0], e)
    axw(`I2CM_INT_STAT_OFS, {28'h0, e});
    axr(`I2CM_INT_STAT_OFS);
    `CHK({irq, rdat[3:0]}, 5'h00)
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    err_total++;
    finish_test();
  end
  initial begin
    i = $urandom(32'h4471c173);
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) begin
      axr(ofs[i]);
      `CHK(rdat, ev[i])
    end
    axr(`I2CM_STATUS_OFS);
    `CHK(rdat[3:0], 4'hC)
    axw(6'h30, 32'h1);
    `CHK(rsp, `I2CM_RESP_SLVERR)
    axr(6'h3C);
    `CHK({rsp, rdat}, {`I2CM_RESP_SLVERR, 32'h0})
    axw(`I2CM_CTRL_OFS, 32'h1E);
    axr(`I2CM_CTRL_OFS);
    `CHK(rdat, 32'h12)
    axw(`I2CM_TARGET_OFS, {25'h0, SLV});
    axw(`I2CM_INT_MASK_OFS, 32'hF);
    for (i = 0; i < 2; i++) begin
      axw(`I2CM_CTRL_OFS, {30'h0, i[0], 1'b1});
      d = $urandom;
      xfer({22'h0, 2'h2, d});
      `CHK(got, d)
      `CHK(lo_max, low_cycles(i ? 15 : 12))
      `CHK(irq, 1'b1)
      clr(4'h1);
    end
    rd_byte <= $urandom;
    xfer(32'h300);
    axr(`I2CM_DATA_CMD_OFS);
    `CHK(rdat[7:0], rd_byte)
    clr(4'h2);
    axw(`I2CM_TARGET_OFS, {25'h0, SLV ^ 7'h01});
    xfer({22'h0, 2'h2, d});
    clr(4'h4);
    axw(`I2CM_INT_MASK_OFS, 32'h0);
    axw(`I2CM_TARGET_OFS, {25'h0, SLV});
    xfer({22'h0, 2'h2, ~d});
    `CHK(irq, 1'b0)
    clr(4'h1);
    `CHK({scl, sda}, 2'b11)
    finish_test();
  end
endmodule
